// *** rtl/pscs_pkg.sv ***
package pscs_pkg;
  localparam int PSCS_STRAP_W = 5;
  // Register offsets of the local plain port
  localparam logic [3:0] PSCS_OFS_CTRL = 4'h0;
  localparam logic [3:0] PSCS_OFS_STAT = 4'h1;
  localparam logic [3:0] PSCS_OFS_VSTAT = 4'h2;
  localparam logic [3:0] PSCS_OFS_LINKMON = 4'h3;
  // Control field positions
  localparam int PSCS_CTRL_ISOLATE = 10;
  localparam int PSCS_CTRL_RATE = 13;
  localparam int PSCS_CTRL_SWRST = 15;
  localparam logic [15:0] PSCS_CTRL_RST = 16'h2000;
  localparam logic [PSCS_STRAP_W-1:0] PSCS_ADDR_NONE = 5'h00;
  // Software reset length
  localparam int PSCS_SWRST_NS = 1000;
  localparam int PSCS_CLK_NS = 25;
  localparam int PSCS_SWRST_CYC = (PSCS_SWRST_NS + PSCS_CLK_NS - 1) / PSCS_CLK_NS;
  typedef enum logic [1:0] {
    PSCS_IF_MII10,
    PSCS_IF_MII100,
    PSCS_IF_SYM100,
    PSCS_IF_SER10
  } pscs_if_mode_t;
  typedef enum {PSCS_ST_RESET, PSCS_ST_SAMPLE, PSCS_ST_RUN} pscs_state_t;
endpackage

// *** rtl/pscs_led_if.sv ***
`timescale 1ns/1ps
interface pscs_led_if;
  logic [4:0] status;
  logic [4:0] sampled;
  logic drive;
  logic [4:0] pin_out;
  logic [4:0] pin_oe;
  modport ctl (output status, output sampled, output drive, input pin_out, input pin_oe);
  modport drv (input status, input sampled, input drive, output pin_out, output pin_oe);
endinterface

// *** rtl/pscs_led_drv.sv ***
`timescale 1ns/1ps
module pscs_led_drv (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_sync_b,
  // Status and strap values
  pscs_led_if.drv led
);
  import pscs_pkg::*;
  logic [PSCS_STRAP_W-1:0] next_pin_out;
  genvar i;
  generate
    for (i = 0; i < PSCS_STRAP_W; i++) begin : g_led
      // Asserted level is opposite of the strap level
      assign next_pin_out[i] = led.status[i] ? ~led.sampled[i] : led.sampled[i];
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      led.pin_out <= '0;
      led.pin_oe <= '0;
    end else begin
      led.pin_out <= next_pin_out;
      led.pin_oe <= {PSCS_STRAP_W{led.drive}};
    end
  end
endmodule // pscs_led_drv

// *** rtl/pscs_top.sv ***
`timescale 1ns/1ps
module pscs_top (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // Configuration pins
  input wire logic hw_or_sw_config,
  input wire logic speed_select_in,
  output logic speed_select_out,
  output logic speed_select_oe,
  input wire logic duplex_select,
  input wire logic autoneg_select,
  input wire logic node_or_repeater_select,
  input wire logic mii_or_serial_select,
  input wire logic rx_tristate_ctl,
  // Strap and indicator pins
  input wire logic [pscs_pkg::PSCS_STRAP_W-1:0] strap_in,
  output logic [pscs_pkg::PSCS_STRAP_W-1:0] strap_out,
  output logic [pscs_pkg::PSCS_STRAP_W-1:0] strap_oe,
  // Link monitor events from the core
  input wire logic mon_activity,
  input wire logic mon_collision,
  input wire logic mon_link_ok,
  input wire logic mon_tx_data,
  input wire logic mon_rx_data,
  input wire logic mon_lock,
  input wire logic mon_an_done,
  // Management serial pins
  input wire logic mgmt_clk_in,
  input wire logic mgmt_data_in,
  input wire logic mgmt_data_core_out,
  input wire logic mgmt_data_core_oe,
  output logic mgmt_clk_core,
  output logic mgmt_data_core_in,
  output logic mgmt_data_out,
  output logic mgmt_data_oe,
  // Status, configuration and host path enables
  output logic link_status_out,
  output logic lock_status_out,
  output logic [4:0] mgmt_addr,
  output logic rx_path_oe,
  output logic tx_path_oe,
  output logic cfg_speed_100,
  output logic cfg_full_duplex,
  output logic cfg_repeater,
  output logic cfg_autoneg,
  output logic [1:0] cfg_if_mode,
  output logic soft_reset_active
);
  import pscs_pkg::*;

  logic rst_meta;
  logic rst_sync_b;
  pscs_state_t state;
  logic [15:0] ctrl;
  logic [$clog2(PSCS_SWRST_CYC+1)-1:0] swrst_cnt;
  logic [PSCS_STRAP_W-1:0] strap_lat;
  logic straps_out;
  logic rate_100;
  pscs_if_mode_t if_mode;
  pscs_led_if led ();

  function automatic pscs_if_mode_t pscs_decode_if(input logic serial, input logic fast);
    if (serial) begin
      pscs_decode_if = fast ? PSCS_IF_SYM100 : PSCS_IF_SER10;
    end else begin
      pscs_decode_if = fast ? PSCS_IF_MII100 : PSCS_IF_MII10;
    end
  endfunction

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync_b <= rst_meta;
    end
  end

  // Strap capture on the second clock edge after synchronized reset release
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      state <= PSCS_ST_RESET;
    end else begin
      case (state)
        PSCS_ST_RESET: state <= PSCS_ST_SAMPLE;
        PSCS_ST_SAMPLE: state <= PSCS_ST_RUN;
        PSCS_ST_RUN: state <= PSCS_ST_RUN;
        default: state <= PSCS_ST_RESET;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      strap_lat <= '0;
      straps_out <= 1'b0;
    end else if (state == PSCS_ST_SAMPLE) begin
      strap_lat <= strap_in;
      straps_out <= 1'b1;
    end
  end

  // Software reset leaves straps untouched
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      ctrl <= PSCS_CTRL_RST;
      swrst_cnt <= '0;
    end else if (swrst_cnt != '0) begin
      swrst_cnt <= swrst_cnt - 1'b1;
      if (swrst_cnt == 1) begin
        ctrl <= PSCS_CTRL_RST;
      end
    end else if (reg_wr && reg_addr == PSCS_OFS_CTRL) begin
      ctrl <= reg_wdata;
      if (reg_wdata[PSCS_CTRL_SWRST]) begin
        swrst_cnt <= ($clog2(PSCS_SWRST_CYC+1))'(PSCS_SWRST_CYC);
      end
    end
  end

  always_comb begin
    rate_100 = hw_or_sw_config ? speed_select_in : ctrl[PSCS_CTRL_RATE];
    if_mode = pscs_decode_if(mii_or_serial_select, rate_100);
  end

  assign led.status = {mon_rx_data, mon_tx_data, mon_link_ok, mon_collision, mon_activity};
  assign led.sampled = strap_lat;
  assign led.drive = straps_out;

  pscs_led_drv u_led (
    .clk(clk),
    .rst_sync_b(rst_sync_b),
    .led(led)
  );

  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      strap_out <= '0;
      strap_oe <= '0;
    end else begin
      strap_out <= led.pin_out;
      strap_oe <= led.pin_oe;
    end
  end

  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      rx_path_oe <= 1'b0;
      tx_path_oe <= 1'b0;
    end else begin
      // Same gating in all interface modes
      rx_path_oe <= straps_out && !rx_tristate_ctl && !ctrl[PSCS_CTRL_ISOLATE]
        && strap_lat != PSCS_ADDR_NONE;
      tx_path_oe <= straps_out && !ctrl[PSCS_CTRL_ISOLATE]
        && strap_lat != PSCS_ADDR_NONE;
    end
  end

  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      cfg_speed_100 <= 1'b0;
      cfg_full_duplex <= 1'b0;
      cfg_repeater <= 1'b0;
      cfg_autoneg <= 1'b0;
      cfg_if_mode <= 2'h0;
      speed_select_out <= 1'b0;
      speed_select_oe <= 1'b0;
      mgmt_addr <= '0;
    end else begin
      cfg_speed_100 <= rate_100;
      cfg_full_duplex <= duplex_select;
      cfg_repeater <= node_or_repeater_select;
      cfg_autoneg <= autoneg_select;
      cfg_if_mode <= if_mode;
      speed_select_out <= ctrl[PSCS_CTRL_RATE];
      speed_select_oe <= !hw_or_sw_config;
      mgmt_addr <= strap_lat;
    end
  end

  // Management pins pass through regardless of mode
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      mgmt_clk_core <= 1'b0;
      mgmt_data_core_in <= 1'b0;
      mgmt_data_out <= 1'b0;
      mgmt_data_oe <= 1'b0;
    end else begin
      mgmt_clk_core <= mgmt_clk_in;
      mgmt_data_core_in <= mgmt_data_in;
      mgmt_data_out <= mgmt_data_core_out;
      mgmt_data_oe <= mgmt_data_core_oe;
    end
  end

  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      link_status_out <= 1'b0;
      lock_status_out <= 1'b0;
      soft_reset_active <= 1'b0;
    end else begin
      link_status_out <= mon_link_ok;
      lock_status_out <= mon_lock;
      soft_reset_active <= swrst_cnt != '0;
    end
  end

  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      case (reg_addr)
        PSCS_OFS_CTRL: reg_rdata <= ctrl;
        PSCS_OFS_STAT: reg_rdata <= {11'h000, strap_lat};
        PSCS_OFS_VSTAT: reg_rdata <= {8'h00, if_mode, rate_100, duplex_select,
          mon_an_done, mon_lock, mon_link_ok, straps_out};
        PSCS_OFS_LINKMON: reg_rdata <= {11'h000, led.status};
        default: reg_rdata <= 16'h0000;
      endcase
    end else begin
      reg_rdata <= 16'h0000;
    end
  end
endmodule // pscs_top

// *** tb/pscs_top_asserts.sv ***
`timescale 1ns/1ps
module pscs_top_asserts (
  // Watched ports
  input wire logic clk,
  input wire logic rst_b,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic hw_or_sw_config,
  input wire logic speed_select_oe,
  input wire logic rx_tristate_ctl,
  input wire logic [4:0] strap_out,
  input wire logic [4:0] strap_oe,
  input wire logic mon_activity,
  input wire logic mon_link_ok,
  input wire logic mon_lock,
  input wire logic mgmt_clk_in,
  input wire logic mgmt_clk_core,
  input wire logic link_status_out,
  input wire logic lock_status_out,
  input wire logic [4:0] mgmt_addr,
  input wire logic rx_path_oe,
  input wire logic tx_path_oe
);
  logic [2:0] up_cnt;
  logic up;
  // Settled once strap sampling is surely over
  assign up = (up_cnt == 3'h7);
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      up_cnt <= 3'h0;
    end else if (!up) begin
      up_cnt <= up_cnt + 3'h1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  AST_RX_TRI: assert property (up && rx_tristate_ctl |=> !rx_path_oe)
    else $error("rx path driven while tri-state pin high");
  AST_ADDR_ZERO: assert property (up && mgmt_addr == 5'h00 |=> !rx_path_oe && !tx_path_oe)
    else $error("host path driven with address zero");
  AST_LINK: assert property (up |=> link_status_out == $past(mon_link_ok) &&
    lock_status_out == $past(mon_lock)) else $error("link or lock output wrong");
  AST_MGMT: assert property (up |=> mgmt_clk_core == $past(mgmt_clk_in))
    else $error("management clock not passed on");
  AST_OE: assert property (up |-> strap_oe == 5'h1f)
    else $error("strap pins not outputs after reset");
  AST_HOLD: assert property (up && $past(up) |-> $stable(mgmt_addr))
    else $error("address resampled");
  AST_ACT: assert property ((up && mon_activity)[*3] |-> strap_out[0] == !mgmt_addr[0])
    else $error("activity indicator level wrong");
  AST_SPEED: assert property (up && $past(up) |-> speed_select_oe == !$past(hw_or_sw_config))
    else $error("speed pin direction wrong");
  AST_RDATA: assert property (up && !reg_rd |=> reg_rdata == 16'h0000)
    else $error("read data outside its cycle");
endmodule // pscs_top_asserts
bind pscs_top pscs_top_asserts i_pscs_top_asserts (.*);

// *** tb/pscs_strap_board.sv ***
`timescale 1ns/1ps
module pscs_strap_board (
  // Board pulls and device drive
  input wire logic [4:0] pull,
  input wire logic [4:0] strap_out,
  input wire logic [4:0] strap_oe,
  // Level at the pins
  output logic [4:0] pin
);
  // Undriven pin settles to its resistor
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      pin[i] = strap_oe[i] ? strap_out[i] : pull[i];
    end
  end
endmodule // pscs_strap_board

// *** tb/pscs_top_tb.sv ***
`timescale 1ns/1ps
module pscs_top_tb;
  import pscs_pkg::*;
  logic clk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, rx_tristate_ctl = 1'b0;
  logic hw_or_sw_config = 1'b1, speed_select_in = 1'b0, duplex_select = 1'b0;
  logic autoneg_select = 1'b0, node_or_repeater_select = 1'b0, mii_or_serial_select = 1'b0;
  logic mgmt_clk_in = 1'b0, mgmt_data_in = 1'b0, mgmt_data_core_out = 1'b0;
  logic mgmt_data_core_oe = 1'b0, mon_lock = 1'b0, mon_an_done = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata, rd;
  logic [4:0] strap_in, strap_out, strap_oe, mgmt_addr, mon = 5'h00, pull = 5'h0b;
  logic [1:0] cfg_if_mode;
  logic speed_select_out, speed_select_oe, mgmt_clk_core, mgmt_data_core_in, mgmt_data_out;
  logic mgmt_data_oe, link_status_out, lock_status_out, rx_path_oe, tx_path_oe;
  logic cfg_speed_100, cfg_full_duplex, cfg_repeater, cfg_autoneg, soft_reset_active;
  int num_errors = 0, check_count = 0;
  pscs_top i_pscs_top (.*, .mon_activity(mon[0]), .mon_collision(mon[1]),
    .mon_link_ok(mon[2]), .mon_tx_data(mon[3]), .mon_rx_data(mon[4]));
  pscs_strap_board i_pscs_strap_board (.pull(pull), .strap_out(strap_out),
    .strap_oe(strap_oe), .pin(strap_in));
  always #12.5 clk = ~clk;
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rdr(input logic [3:0] a, output logic [15:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    d = reg_rdata;
  endtask
  task automatic do_reset(input logic [4:0] p);
    rst_b <= 1'b0;
    pull <= p;
    cyc(3);
    rst_b <= 1'b1;
    cyc(8);
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    #20us;
    num_errors++;
    print_verdict();
  end
  initial begin
    @(posedge clk);
    do_reset(5'h0b);
    chk("mgmt_addr", 16'h000b, {11'h000, mgmt_addr});
    chk("strap_oe", 16'h001f, {11'h000, strap_oe});
    rdr(PSCS_OFS_STAT, rd);
    chk("stat", 16'h000b, rd);
    rdr(PSCS_OFS_CTRL, rd);
    chk("ctrl", PSCS_CTRL_RST, rd);
    rdr(4'hf, rd);
    chk("unmapped", 16'h0000, rd);
    $display("test straps done");
    for (int i = 0; i < 5; i++) begin
      mon <= 5'h01 << i;
      cyc(3);
      chk("strap_out", {11'h000, 5'h0b ^ (5'h01 << i)}, {11'h000, strap_out});
    end
    mon <= 5'h04;
    mon_lock <= 1'b1;
    cyc(3);
    rdr(PSCS_OFS_VSTAT, rd);
    chk("vstat", 16'h0007, rd);
    chk("status pins", 16'h0003, {14'h0000, link_status_out, lock_status_out});
    rdr(PSCS_OFS_LINKMON, rd);
    chk("linkmon", 16'h0004, rd);
    $display("test indicators done");
    for (int i = 0; i < 16; i++) begin
      {mii_or_serial_select, speed_select_in, duplex_select, node_or_repeater_select} <= 4'(i);
      mgmt_clk_in <= i[0];
      rx_tristate_ctl <= i[1];
      {mgmt_data_core_oe, mgmt_data_core_out, mgmt_data_in, autoneg_select} <= 4'(i);
      cyc(3);
      chk("mgmt", {12'h000, i[1], i[2], i[3], i[0]}, {12'h000, mgmt_data_core_in,
        mgmt_data_out, mgmt_data_oe, cfg_autoneg});
      chk("cfg", {9'h000, i[3], i[3] ^ i[2], i[2], i[1], i[0], ~i[1], i[0]},
        {9'h000, cfg_if_mode, cfg_speed_100, cfg_full_duplex, cfg_repeater,
        rx_path_oe, mgmt_clk_core});
    end
    $display("test modes done");
    rx_tristate_ctl <= 1'b0;
    hw_or_sw_config <= 1'b0;
    wr(PSCS_OFS_CTRL, 16'h2400);
    cyc(3);
    chk("isolate", 16'h000c, {12'h000, speed_select_oe, speed_select_out, rx_path_oe,
      tx_path_oe});
    wr(PSCS_OFS_CTRL, 16'h0000);
    cyc(3);
    chk("sw pins", 16'h000b, {12'h000, speed_select_oe, speed_select_out, rx_path_oe,
      tx_path_oe});
    wr(PSCS_OFS_CTRL, 16'h8000);
    cyc(2);
    chk("soft reset", {5'h00, 1'b1, 5'h1f, 5'h0b}, {5'h00, soft_reset_active, strap_oe,
      mgmt_addr});
    cyc(45);
    rdr(PSCS_OFS_CTRL, rd);
    chk("ctrl after soft reset", PSCS_CTRL_RST, rd);
    $display("test software mode done");
    do_reset(5'h00);
    chk("addr zero", 16'h0000, {9'h000, mgmt_addr, rx_path_oe, tx_path_oe});
    chk("strap_oe addr zero", 16'h001f, {11'h000, strap_oe});
    cyc(2);
    chk("addr zero held", 16'h0000, {14'h0000, rx_path_oe, tx_path_oe});
    $display("test address zero done");
    print_verdict();
  end
endmodule // pscs_top_tb
